//--- design/smbr_consts.svh
`ifndef SMBR_CONSTS_SVH
`define SMBR_CONSTS_SVH
`define SMBR_CMD_BLK_WR 8'hF0
`define SMBR_CMD_PROC_CALL 8'hF1
`define SMBR_ADDR_TOP 8'hFF
`define SMBR_REG_LAST 8'hEF
`define SMBR_TIMEOUT_NS 25000000
`define SMBR_REF_PERIOD_NS 50
`endif

//--- design/smbr_pkg.sv
package smbr_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_WBYTE = 6'h04,
    ST_ACK = 6'h08,
    ST_RBYTE = 6'h10,
    ST_RACK = 6'h20
  } smbr_state_e;
  typedef enum logic [7:0] {
    PH_CMD = 8'h01,
    PH_BW_CNT = 8'h02,
    PH_BW_ADDR = 8'h04,
    PH_DATA = 8'h08,
    PH_PC_CNT = 8'h10,
    PH_PC_ADDR = 8'h20,
    PH_PC_LEN = 8'h40,
    PH_SKIP = 8'h80
  } smbr_phase_e;
  typedef enum logic [1:0] {
    OP_WR = 2'h0,
    OP_RD = 2'h1,
    OP_CLR = 2'h2
  } smbr_op_e;
  typedef struct packed {
    smbr_op_e op;
    logic [7:0] addr;
    logic [7:0] data;
  } smbr_req_s;
endpackage

//--- design/smbr_sync.sv
`timescale 1ns/1ps
module smbr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  if (W < 1) $error("smbr_sync: W must be positive");
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

//--- design/smbr_hs.sv
`timescale 1ns/1ps
module smbr_hs #(
  parameter int W = 8
) (
  input wire logic s_clk,
  input wire logic s_rst_n,
  input wire logic s_ce,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [W-1:0] s_data,
  input wire logic d_clk,
  input wire logic d_rst_n,
  input wire logic d_ce,
  output logic d_valid,
  output logic [W-1:0] d_data
);
  logic req_q;
  logic ack_s;
  logic req_s;
  logic seen_q;
  logic [W-1:0] hold_q;
  if (W < 1) $error("smbr_hs: W must be positive");
  // word is held stable until the far side echoes the toggle
  always_ff @(posedge s_clk or negedge s_rst_n)
  begin
    if (!s_rst_n)
    begin
      req_q <= 1'b0;
      hold_q <= '0;
    end
    else if (s_ce && s_valid && s_ready)
    begin
      req_q <= ~req_q;
      hold_q <= s_data;
    end
  end
  assign s_ready = (req_q == ack_s);
  smbr_sync #(.W(1)) u_ack (
    .clk(s_clk),
    .rst_n(s_rst_n),
    .d(seen_q),
    .q(ack_s)
  );
  smbr_sync #(.W(1)) u_req (
    .clk(d_clk),
    .rst_n(d_rst_n),
    .d(req_q),
    .q(req_s)
  );
  always_ff @(posedge d_clk or negedge d_rst_n)
  begin
    if (!d_rst_n)
    begin
      seen_q <= 1'b0;
      d_valid <= 1'b0;
      d_data <= '0;
    end
    else if (d_ce)
    begin
      d_valid <= (req_s != seen_q);
      seen_q <= req_s;
      if (req_s != seen_q)
        d_data <= hold_q;
    end
  end
endmodule

//--- design/smbr_top.sv
`timescale 1ns/1ps
`include "smbr_consts.svh"
// Notes on behaviour
// - transaction opens with start, address and read/write bit; ack own address only
// - word write: register address, low byte, high byte, each acked, then stop
// - first byte F0 after write address selects command-coded block write
// - block write: command, count, start address, then data, all acked
// - block write count byte is ignored; any number of data bytes accepted
// - no thirty-two byte limit on block write length
// - writes outside implemented space are acked but change nothing
// - block write address sticks at FF, never wraps to 00
// - plain block write: start address byte then data bytes until stop
// - byte read: address write, repeated start, read address, one byte
// - word read returns low byte then next byte, master nacks the second
// - command F1 in write phase is the process call and is acked
// - process call read returns the length byte first, then register bytes
// - latched base address does not advance after an access
// - reads outside implemented space return 00
// - start or stop mid-byte drops the partial byte and its side effect
// - a line held low past the timeout forces idle; device reset does not
module smbr_top #(
  // default bus address is arbitrary
  parameter logic [6:0] OWN_ADDR = 7'h2C,
  parameter int TIMEOUT_CYC = `SMBR_TIMEOUT_NS / `SMBR_REF_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic link_nrst,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic reg_wr,
  output logic reg_rd,
  output logic reg_rd_done,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  if (TIMEOUT_CYC < 2) $error("smbr_top: TIMEOUT_CYC too small");

  function automatic logic in_space(input logic [7:0] a);
    return a <= `SMBR_REG_LAST;
  endfunction
  function automatic logic [7:0] inc_clamp(input logic [7:0] a);
    return (a == `SMBR_ADDR_TOP) ? a : a + 8'h01;
  endfunction

  // ---- reference clock side: timeout and register port
  logic [1:0] pins_r;
  logic [CW-1:0] to_cnt_q;
  logic to_q;
  smbr_pkg::smbr_req_s req_r;
  logic req_dv;
  logic reg_wr_q;
  logic reg_rd_q;
  logic reg_done_q;
  logic [7:0] reg_addr_q;
  logic [7:0] reg_wdata_q;

  smbr_sync #(.W(2)) u_pin_r (
    .clk(ref_clk),
    .rst_n(nrst),
    .d({scl_i, sda_i}),
    .q(pins_r)
  );

  // either line low too long; level stays up until both lines are high
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      to_cnt_q <= '0;
      to_q <= 1'b0;
    end
    else if (ce)
    begin
      if (&pins_r)
      begin
        to_cnt_q <= '0;
        to_q <= 1'b0;
      end
      else if (to_cnt_q == CW'(TIMEOUT_CYC - 1))
        to_q <= 1'b1;
      else
        to_cnt_q <= to_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_done_q <= 1'b0;
      reg_addr_q <= 8'h00;
      reg_wdata_q <= 8'h00;
    end
    else if (ce)
    begin
      reg_wr_q <= req_dv && req_r.op == smbr_pkg::OP_WR;
      reg_rd_q <= req_dv && req_r.op == smbr_pkg::OP_RD;
      reg_done_q <= req_dv && req_r.op == smbr_pkg::OP_CLR;
      if (req_dv)
      begin
        reg_addr_q <= req_r.addr;
        reg_wdata_q <= req_r.data;
      end
    end
  end
  assign reg_wr = reg_wr_q;
  assign reg_rd = reg_rd_q;
  assign reg_rd_done = reg_done_q;
  assign reg_addr = reg_addr_q;
  assign reg_wdata = reg_wdata_q;

  // ---- link side: protocol engine, oversamples the bus lines
  logic [3:0] pins_l;
  logic ce_l;
  logic to_l;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] byte_c;
  smbr_pkg::smbr_state_e state_q;
  smbr_pkg::smbr_phase_e phase_q;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic rw_q;
  logic pc_q;
  logic first_q;
  logic acked_q;
  logic need_q;
  logic rd_ok_q;
  logic [7:0] base_q;
  logic [7:0] ptr_q;
  logic [7:0] rd_ptr_q;
  logic [7:0] len_q;
  logic [7:0] rd_data_q;
  smbr_pkg::smbr_req_s req_q;
  logic req_v_q;
  logic req_rdy;
  logic hs_free;
  logic rsp_v;
  logic [7:0] rsp_data;
  logic sda_oe_q;
  logic scl_oe_q;

  smbr_sync #(.W(4)) u_pin_l (
    .clk(link_clk),
    .rst_n(link_nrst),
    .d({ce, to_q, scl_i, sda_i}),
    .q(pins_l)
  );
  assign {ce_l, to_l, scl_s, sda_s} = pins_l;

  smbr_hs #(.W($bits(smbr_pkg::smbr_req_s))) u_req (
    .s_clk(link_clk),
    .s_rst_n(link_nrst),
    .s_ce(ce_l),
    .s_valid(req_v_q),
    .s_ready(req_rdy),
    .s_data(req_q),
    .d_clk(ref_clk),
    .d_rst_n(nrst),
    .d_ce(ce),
    .d_valid(req_dv),
    .d_data(req_r)
  );
  // user answers reg_rd in the same cycle on reg_rdata
  smbr_hs #(.W(8)) u_rsp (
    .s_clk(ref_clk),
    .s_rst_n(nrst),
    .s_ce(ce),
    .s_valid(reg_rd_q),
    .s_ready(),
    .s_data(reg_rdata),
    .d_clk(link_clk),
    .d_rst_n(link_nrst),
    .d_ce(ce_l),
    .d_valid(rsp_v),
    .d_data(rsp_data)
  );

  always_ff @(posedge link_clk or negedge link_nrst)
  begin
    if (!link_nrst)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else if (ce_l)
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign byte_c = {shift_q[6:0], sda_s};
  assign hs_free = req_rdy & ~req_v_q;

  // only link_nrst (power-on) clears the engine; nrst never touches it
  always_ff @(posedge link_clk or negedge link_nrst)
  begin
    if (!link_nrst)
    begin
      state_q <= smbr_pkg::ST_IDLE;
      phase_q <= smbr_pkg::PH_CMD;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      rw_q <= 1'b0;
      pc_q <= 1'b0;
      first_q <= 1'b0;
      acked_q <= 1'b0;
      need_q <= 1'b0;
      rd_ok_q <= 1'b0;
      base_q <= 8'h00;
      ptr_q <= 8'h00;
      rd_ptr_q <= 8'h00;
      len_q <= 8'h00;
      rd_data_q <= 8'h00;
      req_q <= '0;
      req_v_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end
    else if (ce_l)
    begin
      if (req_v_q && req_rdy)
        req_v_q <= 1'b0;
      if (rsp_v)
      begin
        rd_data_q <= rsp_data;
        rd_ok_q <= 1'b1;
      end
      // fetch waits off rising edges so it never races a commit
      if (need_q && hs_free && !scl_rise)
      begin
        need_q <= 1'b0;
        if (in_space(rd_ptr_q))
        begin
          req_q <= '{smbr_pkg::OP_RD, rd_ptr_q, 8'h00};
          req_v_q <= 1'b1;
        end
        else
        begin
          rd_data_q <= 8'h00;
          rd_ok_q <= 1'b1;
        end
      end
      if (to_l || stop_c)
      begin
        state_q <= smbr_pkg::ST_IDLE;
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
        acked_q <= 1'b0;
        need_q <= 1'b0;
        pc_q <= 1'b0;
      end
      else if (start_c)
      begin
        state_q <= smbr_pkg::ST_ADDR;
        bit_q <= 4'h0;
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
        acked_q <= 1'b0;
        need_q <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          smbr_pkg::ST_IDLE:
            ;
          smbr_pkg::ST_ADDR, smbr_pkg::ST_WBYTE:
            if (scl_rise)
            begin
              shift_q <= byte_c;
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7 && state_q == smbr_pkg::ST_ADDR)
              begin
                bit_q <= 4'h0;
                if (byte_c[7:1] == OWN_ADDR)
                begin
                  state_q <= smbr_pkg::ST_ACK;
                  rw_q <= byte_c[0];
                  if (!byte_c[0])
                    phase_q <= smbr_pkg::PH_CMD;
                  else
                  begin
                    rd_ptr_q <= base_q;
                    first_q <= pc_q;
                    rd_ok_q <= pc_q;
                    need_q <= ~pc_q;
                    if (pc_q)
                      rd_data_q <= len_q;
                  end
                end
                else
                  state_q <= smbr_pkg::ST_IDLE;
              end
              else if (bit_q == 4'h7)
              begin
                bit_q <= 4'h0;
                state_q <= smbr_pkg::ST_ACK;
                unique case (phase_q)
                  smbr_pkg::PH_CMD:
                    if (byte_c == `SMBR_CMD_BLK_WR)
                      phase_q <= smbr_pkg::PH_BW_CNT;
                    else if (byte_c == `SMBR_CMD_PROC_CALL)
                    begin
                      phase_q <= smbr_pkg::PH_PC_CNT;
                      pc_q <= 1'b1;
                    end
                    else
                    begin
                      base_q <= byte_c;
                      ptr_q <= byte_c;
                      pc_q <= 1'b0;
                      phase_q <= smbr_pkg::PH_DATA;
                    end
                  smbr_pkg::PH_BW_CNT:
                    phase_q <= smbr_pkg::PH_BW_ADDR;
                  smbr_pkg::PH_BW_ADDR:
                  begin
                    ptr_q <= byte_c;
                    base_q <= byte_c;
                    phase_q <= smbr_pkg::PH_DATA;
                  end
                  smbr_pkg::PH_DATA:
                  begin
                    if (in_space(ptr_q))
                    begin
                      req_q <= '{smbr_pkg::OP_WR, ptr_q, byte_c};
                      req_v_q <= 1'b1;
                    end
                    ptr_q <= inc_clamp(ptr_q);
                  end
                  smbr_pkg::PH_PC_CNT:
                    phase_q <= smbr_pkg::PH_PC_ADDR;
                  smbr_pkg::PH_PC_ADDR:
                  begin
                    base_q <= byte_c;
                    phase_q <= smbr_pkg::PH_PC_LEN;
                  end
                  smbr_pkg::PH_PC_LEN:
                  begin
                    len_q <= byte_c;
                    phase_q <= smbr_pkg::PH_SKIP;
                  end
                  smbr_pkg::PH_SKIP:
                    ;
                endcase
              end
            end
          smbr_pkg::ST_ACK, smbr_pkg::ST_RACK:
            if (state_q == smbr_pkg::ST_RACK && scl_rise)
            begin
              // commit only once the whole byte went out
              if (!first_q && in_space(rd_ptr_q))
              begin
                req_q <= '{smbr_pkg::OP_CLR, rd_ptr_q, 8'h00};
                req_v_q <= 1'b1;
              end
              if (sda_s)
                state_q <= smbr_pkg::ST_IDLE;
              else
              begin
                acked_q <= 1'b1;
                need_q <= 1'b1;
                rd_ok_q <= 1'b0;
                first_q <= 1'b0;
                if (!first_q)
                  rd_ptr_q <= inc_clamp(rd_ptr_q);
              end
            end
            else if (state_q == smbr_pkg::ST_ACK && !sda_oe_q)
            begin
              if (scl_fall)
                sda_oe_q <= 1'b1;
            end
            else if ((state_q == smbr_pkg::ST_ACK || acked_q) &&
                     (scl_fall || scl_oe_q))
            begin
              // stretch the clock until the crossing is idle and data is in
              if (!hs_free || (rw_q && !rd_ok_q))
                scl_oe_q <= 1'b1;
              else
              begin
                scl_oe_q <= 1'b0;
                acked_q <= 1'b0;
                if (rw_q)
                begin
                  state_q <= smbr_pkg::ST_RBYTE;
                  sda_oe_q <= ~rd_data_q[7];
                  shift_q <= {rd_data_q[6:0], 1'b0};
                  bit_q <= 4'h1;
                end
                else
                begin
                  state_q <= smbr_pkg::ST_WBYTE;
                  sda_oe_q <= 1'b0;
                  bit_q <= 4'h0;
                end
              end
            end
          smbr_pkg::ST_RBYTE:
            if (scl_fall)
            begin
              if (bit_q == 4'h8)
              begin
                state_q <= smbr_pkg::ST_RACK;
                sda_oe_q <= 1'b0;
              end
              else
              begin
                sda_oe_q <= ~shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
        endcase
      end
    end
  end
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign scl_oe = scl_oe_q;

  sequence s_quiet;
    ce_l && !start_c && !stop_c && !to_l;
  endsequence
  sequence s_wdone(logic [7:0] ph);
    state_q == smbr_pkg::ST_WBYTE && phase_q == ph && scl_rise &&
      bit_q == 4'h7;
  endsequence

  a_addr_foreign: assert property (@(posedge link_clk) disable iff (!link_nrst)
    (state_q == smbr_pkg::ST_ADDR && scl_rise && bit_q == 4'h7 &&
     byte_c[7:1] != OWN_ADDR) ##0 s_quiet
    |=> state_q == smbr_pkg::ST_IDLE && !sda_oe_q)
    else $error("foreign address not ignored");
  a_ack_drive: assert property (@(posedge link_clk) disable iff (!link_nrst)
    (state_q == smbr_pkg::ST_ACK && !sda_oe_q && scl_fall) ##0 s_quiet
    |=> sda_oe_q)
    else $error("ack not driven");
  a_blk_cmd: assert property (@(posedge link_clk) disable iff (!link_nrst)
    s_wdone(smbr_pkg::PH_CMD) ##0 (byte_c == `SMBR_CMD_BLK_WR) ##0 s_quiet
    |=> phase_q == smbr_pkg::PH_BW_CNT)
    else $error("block write command missed");
  a_pc_cmd: assert property (@(posedge link_clk) disable iff (!link_nrst)
    s_wdone(smbr_pkg::PH_CMD) ##0 (byte_c == `SMBR_CMD_PROC_CALL) ##0 s_quiet
    |=> phase_q == smbr_pkg::PH_PC_CNT && pc_q)
    else $error("process call command missed");
  a_cnt_skip: assert property (@(posedge link_clk) disable iff (!link_nrst)
    s_wdone(smbr_pkg::PH_BW_CNT) ##0 s_quiet
    |=> phase_q == smbr_pkg::PH_BW_ADDR && ptr_q == $past(ptr_q))
    else $error("count byte not ignored");
  a_ptr_clamp: assert property (@(posedge link_clk) disable iff (!link_nrst)
    (phase_q == smbr_pkg::PH_DATA && ptr_q == `SMBR_ADDR_TOP && ce_l)
    |=> ptr_q == `SMBR_ADDR_TOP)
    else $error("write address wrapped");
  a_wr_space: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr_q |-> reg_addr_q <= `SMBR_REG_LAST)
    else $error("write outside register space");
  a_pc_count: assert property (@(posedge link_clk) disable iff (!link_nrst)
    (state_q == smbr_pkg::ST_ADDR && scl_rise && bit_q == 4'h7 &&
     byte_c == {OWN_ADDR, 1'b1} && pc_q) ##0 s_quiet
    |=> rd_data_q == len_q && rd_ok_q && first_q)
    else $error("count byte not first");
  a_base_hold: assert property (@(posedge link_clk) disable iff (!link_nrst)
    (state_q == smbr_pkg::ST_RACK) |=> base_q == $past(base_q))
    else $error("base address advanced");
  a_to_idle: assert property (@(posedge link_clk) disable iff (!link_nrst)
    (to_l && ce_l) |=> state_q == smbr_pkg::ST_IDLE && !sda_oe_q &&
    !scl_oe_q)
    else $error("timeout did not idle");
  a_part_drop: assert property (@(posedge link_clk) disable iff (!link_nrst)
    (state_q == smbr_pkg::ST_WBYTE && bit_q != 4'h0 &&
     (start_c || stop_c) && ce_l) |=> !$rose(req_v_q))
    else $error("partial byte committed");
  a_read_zero: assert property (@(posedge link_clk) disable iff (!link_nrst)
    (need_q && hs_free && !scl_rise && !in_space(rd_ptr_q) && ce_l &&
     !rsp_v) |=> rd_data_q == 8'h00 && rd_ok_q)
    else $error("out of space read not zero");
endmodule

//--- bench/smbr_master.sv
`timescale 1ns/1ps
// bus master model; lines are open drain, so it only ever pulls low
module smbr_master (
  input wire logic clk,
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_lo,
  output logic sda_lo
);
  int hangs = 0;
  initial
  begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data changes only while scl is low; stretch honoured, bounded
  task automatic clk_bit(input logic b, output logic r);
    int k;
    sda_lo <= ~b;
    w(8);
    scl_lo <= 1'b0;
    for (k = 0; k < 4000 && !(k > 0 && scl_w); k++) w(1);
    if (k == 4000) hangs++;
    w(4);
    r = sda_w;
    w(4);
    scl_lo <= 1'b1;
  endtask
  task automatic start();
    sda_lo <= 1'b0;
    w(8);
    scl_lo <= 1'b0;
    w(8);
    sda_lo <= 1'b1;
    w(8);
    scl_lo <= 1'b1;
  endtask
  task automatic stop();
    sda_lo <= 1'b1;
    w(8);
    scl_lo <= 1'b0;
    w(8);
    sda_lo <= 1'b0;
    w(8);
  endtask
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic byte_rx(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(~ack, r);
  endtask
endmodule

//--- bench/tb_smbr_top.sv
`timescale 1ns/1ps
module tb_smbr_top;
  logic ref_clk, link_clk, nrst, link_nrst, ce;
  logic scl_lo, sda_lo, scl_o, scl_oe, sda_o, sda_oe;
  logic reg_wr, reg_rd, reg_rd_done;
  logic [7:0] reg_addr, reg_wdata;
  logic [7:0] mem [256];
  wire scl_w = ~(scl_lo | scl_oe);
  wire sda_w = ~(sda_lo | sda_oe);
  wire [7:0] reg_rdata = mem[reg_addr];
  int errors = 0;
  int checks_done = 0;
  int wr_cnt = 0;
  int done_cnt = 0;
  int rd_cnt = 0;
  smbr_top #(.TIMEOUT_CYC(2000)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .ce(ce), .link_clk(link_clk), .link_nrst(link_nrst), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_done(reg_rd_done), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  smbr_master i_mst (.clk(ref_clk), .scl_w(scl_w), .sda_w(sda_w),
    .scl_lo(scl_lo), .sda_lo(sda_lo));
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // register space stand-in; the part beyond EF must never be touched
  always @(posedge ref_clk)
    if (reg_wr === 1'b1)
    begin
      mem[reg_addr] <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  // read strobes seen at the register side
  always @(posedge ref_clk)
  begin
    if (reg_rd_done === 1'b1)
      done_cnt <= done_cnt + 1;
    if (reg_rd === 1'b1)
      rd_cnt <= rd_cnt + 1;
  end
  task automatic end_of_test();
    errors += i_mst.hangs;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tx(input logic [7:0] d, input logic a);
    logic k;
    i_mst.byte_tx(d, k);
    chk({7'h00, k}, {7'h00, a});
  endtask
  task automatic rx(input logic [7:0] e, input logic ack);
    logic [7:0] d;
    i_mst.byte_rx(d, ack);
    chk(d, e);
  endtask
  task automatic fin();
    i_mst.stop();
    i_mst.w(40);
  endtask
  task automatic sc_word_write();
    i_mst.start();
    tx(8'h58, 1'b1);
    tx(8'h10, 1'b1);
    tx(8'h34, 1'b1);
    tx(8'h12, 1'b1);
    fin();
    chk(mem[8'h10], 8'h34);
    chk(mem[8'h11], 8'h12);
  endtask
  task automatic sc_foreign();
    int n = wr_cnt;
    i_mst.start();
    tx(8'h5A, 1'b0);
    tx(8'h10, 1'b0);
    fin();
    chk(8'(wr_cnt - n), 8'h00);
  endtask
  task automatic sc_blk_cmd();
    i_mst.start();
    tx(8'h58, 1'b1);
    tx(8'hF0, 1'b1);
    tx(8'h02, 1'b1);
    tx(8'hEE, 1'b1);
    tx(8'hA1, 1'b1);
    tx(8'hA2, 1'b1);
    tx(8'hA3, 1'b1);
    fin();
    chk(mem[8'hEE], 8'hA1);
    chk(mem[8'hEF], 8'hA2);
    chk(mem[8'hF0], 8'h0F);
  endtask
  // a wrap past FF would land in register 00, which is writable
  task automatic sc_blk_top();
    int n = wr_cnt;
    i_mst.start();
    tx(8'h58, 1'b1);
    tx(8'hFE, 1'b1);
    tx(8'h11, 1'b1);
    tx(8'h22, 1'b1);
    tx(8'h33, 1'b1);
    fin();
    chk(8'(wr_cnt - n), 8'h00);
    chk(mem[8'h00], 8'hFF);
  endtask
  task automatic sc_blk_long();
    i_mst.start();
    tx(8'h58, 1'b1);
    tx(8'h20, 1'b1);
    for (int i = 0; i < 34; i++) tx(8'(i + 8'h80), 1'b1);
    fin();
    for (int i = 0; i < 34; i++) chk(mem[8'h20 + i], 8'(i + 8'h80));
  endtask
  task automatic sc_reads();
    int d = done_cnt;
    int q;
    i_mst.start();
    tx(8'h58, 1'b1);
    tx(8'h10, 1'b1);
    i_mst.start();
    tx(8'h59, 1'b1);
    rx(8'h34, 1'b0);
    fin();
    chk(8'(done_cnt - d), 8'h01);
    i_mst.start();
    tx(8'h59, 1'b1);
    rx(8'h34, 1'b1);
    rx(8'h12, 1'b0);
    fin();
    chk(8'(done_cnt - d), 8'h03);
    d = done_cnt;
    q = rd_cnt;
    i_mst.start();
    tx(8'h58, 1'b1);
    tx(8'hF5, 1'b1);
    i_mst.start();
    tx(8'h59, 1'b1);
    rx(8'h00, 1'b0);
    fin();
    chk(8'(rd_cnt - q), 8'h00);
    chk(8'(done_cnt - d), 8'h00);
  endtask
  task automatic sc_proc_call();
    int d = done_cnt;
    i_mst.start();
    tx(8'h58, 1'b1);
    tx(8'hF1, 1'b1);
    tx(8'h02, 1'b1);
    tx(8'h20, 1'b1);
    tx(8'h03, 1'b1);
    i_mst.start();
    tx(8'h59, 1'b1);
    rx(8'h03, 1'b1);
    rx(8'h80, 1'b1);
    rx(8'h81, 1'b1);
    rx(8'h82, 1'b0);
    fin();
    chk(8'(done_cnt - d), 8'h03);
  endtask
  task automatic sc_abort();
    logic r;
    int n = wr_cnt;
    int d = done_cnt;
    i_mst.start();
    tx(8'h58, 1'b1);
    tx(8'h10, 1'b1);
    for (int i = 0; i < 4; i++) i_mst.clk_bit(1'b0, r);
    fin();
    chk(8'(wr_cnt - n), 8'h00);
    // engine must drop back to idle, so a byte without start is ignored
    i_mst.start();
    tx(8'h58, 1'b1);
    tx(8'h10, 1'b1);
    i_mst.w(2500);
    tx(8'h99, 1'b0);
    fin();
    chk(mem[8'h10], 8'h34);
    // read cut after two bits; the third bit of 34 leaves the line free
    d = done_cnt;
    i_mst.start();
    tx(8'h58, 1'b1);
    tx(8'h10, 1'b1);
    i_mst.start();
    tx(8'h59, 1'b1);
    for (int i = 0; i < 2; i++) i_mst.clk_bit(1'b1, r);
    fin();
    chk(8'(done_cnt - d), 8'h00);
  endtask
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = ~8'(i);
    nrst = 1'b0;
    link_nrst = 1'b0;
    ce = 1'b1;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    link_nrst <= 1'b1;
    i_mst.w(10);
    sc_word_write();
    sc_foreign();
    sc_blk_cmd();
    sc_blk_top();
    sc_blk_long();
    sc_reads();
    sc_proc_call();
    sc_abort();
    end_of_test();
  end
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
endmodule
